// file: rtl/hsv_capability.sv
// hot-swap and product-data capability entries with eeprom access sequencer
//
// Overview of operation
// - set insertion status once eeprom load done and pci disable clear; write one clears
// - set extraction status when handle switch high outside reset; write one clears
// - hot-swap capability identifier reads 0x06
// - hot-swap next pointer reads 0xE8 with product data enabled, else 0x00
// - writing flag one stores the four data bytes into the eeprom
// - flag returns to zero when that eeprom write finishes
// - writing flag zero fetches four eeprom bytes into the data word
// - flag goes to one when that eeprom read finishes
// - product-data next pointer is read-only 0x00
// - product-data capability identifier is read-only 0x03
// - low data byte holds the eeprom byte at the programmed address with its two low bits cleared
`timescale 1ns/1ps
module hsv_capability (
  input wire logic mclk,
  input wire logic srst,
  // configuration access port, one-cycle strobes
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // device status inputs from same-clock logic
  input wire logic eeprom_load_done,
  input wire logic pci_disable_bit,
  input wire logic vpd_enable,
  // handle switch pin, asynchronous
  input wire logic handle_switch_input,
  // request to the serial eeprom engine
  output logic ee_req,
  output logic ee_write,
  output logic [7:0] ee_addr,
  output logic [31:0] ee_wdata,
  input wire logic ee_done,
  input wire logic [31:0] ee_rdata,
  // board signals
  output logic led_on,
  output logic enum_n
);
  typedef struct packed {
    logic insertion_status;
    logic extraction_status;
    logic led_control;
    logic enum_interrupt_mask;
    logic product_data_flag;
    logic [7:0] product_data_address;
    logic [31:0] product_data_word;
    hsv_pkg::hsv_state_t state;
    logic ee_req;
    logic ee_write;
    logic [7:0] ee_addr;
    logic [31:0] ee_wdata;
    logic [31:0] rdata;
    logic ack;
    logic led_on;
    logic enum_n;
  } hsv_regs_t;

  hsv_regs_t r;
  hsv_regs_t next_r;
  logic switch_s;
  logic rd_hit;
  logic [31:0] rd_data;
  logic wr_hs;
  logic wr_pd;
  logic wr_word;
  logic flag_written;
  logic insertion_event;
  logic extraction_event;
  logic hs_ctl_write;
  logic addr_write;
  logic [31:0] word_merge;

  // handle switch is a pin, so it is synchronised before use
  hsv_sync u_switch_sync (
    .mclk(mclk),
    .srst(srst),
    .din(handle_switch_input),
    .dout(switch_s)
  );

  hsv_cfg_read u_read (
    .addr(cfg_addr),
    .insertion(r.insertion_status),
    .extraction(r.extraction_status),
    .led(r.led_control),
    .mask(r.enum_interrupt_mask),
    .vpd_enable(vpd_enable),
    .flag(r.product_data_flag),
    .pd_addr(r.product_data_address),
    .pd_word(r.product_data_word),
    .hit(rd_hit),
    .data(rd_data)
  );

  // address decode of writes
  assign wr_hs = cfg_wr && (cfg_addr == hsv_pkg::hot_swap_ofs);
  assign wr_pd = cfg_wr && (cfg_addr == hsv_pkg::product_data_ofs);
  assign wr_word = cfg_wr && (cfg_addr == hsv_pkg::product_word_ofs);
  assign flag_written = wr_pd && cfg_be[3];
  // control byte of the hot-swap word and address byte of the product-data word
  assign hs_ctl_write = wr_hs && cfg_be[2];
  assign addr_write = wr_pd && cfg_be[2];

  // status events; srst is the pci reset, so sampling outside srst means reset negated
  assign insertion_event = eeprom_load_done && !pci_disable_bit;
  assign extraction_event = switch_s;

  // data word merge, one lane per byte enable
  for (genvar g = 0; g < 4; g++) begin : g_word_lane
    assign word_merge[g*8 +: 8] = (wr_word && cfg_be[g]) ? cfg_wdata[g*8 +: 8]
                                  : r.product_data_word[g*8 +: 8];
  end

  always_comb begin
    next_r = r;
    next_r.ack = cfg_wr || cfg_rd;
    // unmapped reads answer zero but are still acknowledged
    next_r.rdata = (cfg_rd && rd_hit) ? rd_data : 32'h00000000;

    // write-one-to-clear first; a new event below wins over the clear
    if (hs_ctl_write) begin
      if (cfg_wdata[hsv_pkg::insertion_pos]) begin
        next_r.insertion_status = 1'b0;
      end
      if (cfg_wdata[hsv_pkg::extraction_pos]) begin
        next_r.extraction_status = 1'b0;
      end
      next_r.led_control = cfg_wdata[hsv_pkg::led_pos];
      next_r.enum_interrupt_mask = cfg_wdata[hsv_pkg::mask_pos];
    end
    if (insertion_event) begin
      next_r.insertion_status = 1'b1;
    end
    if (extraction_event) begin
      next_r.extraction_status = 1'b1;
    end

    // address field is plain storage; the sequencer aligns the eeprom address to four bytes
    if (addr_write) begin
      next_r.product_data_address = cfg_wdata[hsv_pkg::addr_lsb +: 8];
    end
    // data word is writable by bytes; the eeprom return overrides below
    next_r.product_data_word = word_merge;

    // eeprom access sequencer
    case (r.state)
      hsv_pkg::st_idle: begin
        if (flag_written) begin
          next_r.product_data_flag = cfg_wdata[hsv_pkg::flag_pos];
          next_r.ee_req = 1'b1;
          next_r.ee_write = cfg_wdata[hsv_pkg::flag_pos];
          // eeprom address forced to a four-byte boundary
          next_r.ee_addr = {r.product_data_address[7:2], 2'b00};
          if (wr_pd && cfg_be[2]) begin
            next_r.ee_addr = {cfg_wdata[hsv_pkg::addr_lsb + 2 +: 6], 2'b00};
          end
          // word written earlier goes out intact
          next_r.ee_wdata = r.product_data_word;
          if (cfg_wdata[hsv_pkg::flag_pos]) begin
            next_r.state = hsv_pkg::st_write;
          end else begin
            next_r.state = hsv_pkg::st_read;
          end
        end
      end
      hsv_pkg::st_write: begin
        // flag writes during a transfer are ignored so the handshake stays intact
        if (ee_done) begin
          next_r.ee_req = 1'b0;
          next_r.product_data_flag = 1'b0;
          next_r.state = hsv_pkg::st_idle;
        end
      end
      hsv_pkg::st_read: begin
        if (ee_done) begin
          next_r.ee_req = 1'b0;
          // ee_rdata[7:0] is the byte at the aligned address
          next_r.product_data_word = ee_rdata;
          next_r.product_data_flag = 1'b1;
          next_r.state = hsv_pkg::st_idle;
        end
      end
      default: begin
        next_r.state = hsv_pkg::st_idle;
        next_r.ee_req = 1'b0;
      end
    endcase

    // board outputs registered from the next state
    next_r.led_on = next_r.led_control;
    next_r.enum_n = !((next_r.insertion_status || next_r.extraction_status)
                      && !next_r.enum_interrupt_mask);

    if (srst) begin
      next_r = '0;
      next_r.state = hsv_pkg::st_idle;
      next_r.product_data_address = hsv_pkg::addr_reset;
      next_r.product_data_word = hsv_pkg::word_reset;
      next_r.enum_n = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    r <= next_r;
  end

  // all outputs straight from flip-flops
  assign cfg_rdata = r.rdata;
  assign cfg_ack = r.ack;
  assign ee_req = r.ee_req;
  assign ee_write = r.ee_write;
  assign ee_addr = r.ee_addr;
  assign ee_wdata = r.ee_wdata;
  assign led_on = r.led_on;
  assign enum_n = r.enum_n;
endmodule : hsv_capability

// file: rtl/hsv_pkg.sv
// package: offsets, field positions, reset values and states of the hot-swap / product-data block
package hsv_pkg;
  // register byte offsets in configuration space
  localparam logic [7:0] hot_swap_ofs = 8'he4;
  localparam logic [7:0] product_data_ofs = 8'he8;
  localparam logic [7:0] product_word_ofs = 8'hec;
  // hot-swap control/status field positions
  localparam int insertion_pos = 23;
  localparam int extraction_pos = 22;
  localparam int led_pos = 19;
  localparam int mask_pos = 17;
  // product-data control field positions
  localparam int flag_pos = 31;
  localparam int addr_lsb = 16;
  // fixed list values
  localparam logic [7:0] hs_ident = 8'h06;
  localparam logic [7:0] pd_ident = 8'h03;
  localparam logic [7:0] hs_next_pd = 8'he8;
  localparam logic [7:0] list_end = 8'h00;
  // reset values
  localparam logic [7:0] addr_reset = 8'h00;
  localparam logic [31:0] word_reset = 32'h00000000;
  // eeprom access sequencer states
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_write = 3'b010,
    st_read = 3'b100
  } hsv_state_t;
endpackage : hsv_pkg

// file: rtl/hsv_sync.sv
// two-flop synchroniser for a level arriving from a pin
`timescale 1ns/1ps
module hsv_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } hsv_sync_t;
  hsv_sync_t r;
  hsv_sync_t next_r;

  // the first stage feeds only the second
  always_comb begin
    next_r.meta = din;
    next_r.stable = r.meta;
    if (srst) begin
      next_r = '0;
    end
  end

  always_ff @(posedge mclk) begin
    r <= next_r;
  end

  assign dout = r.stable;
endmodule : hsv_sync

// file: rtl/hsv_cfg_read.sv
// read multiplexer for the three configuration words
`timescale 1ns/1ps
module hsv_cfg_read (
  input wire logic [7:0] addr,
  input wire logic insertion,
  input wire logic extraction,
  input wire logic led,
  input wire logic mask,
  input wire logic vpd_enable,
  input wire logic flag,
  input wire logic [7:0] pd_addr,
  input wire logic [31:0] pd_word,
  output logic hit,
  output logic [31:0] data
);
  // reserved bits read as zero; unmapped offsets return zero with hit low
  always_comb begin
    data = 32'h00000000;
    hit = 1'b1;
    case (addr)
      hsv_pkg::hot_swap_ofs: begin
        data[hsv_pkg::insertion_pos] = insertion;
        data[hsv_pkg::extraction_pos] = extraction;
        data[hsv_pkg::led_pos] = led;
        data[hsv_pkg::mask_pos] = mask;
        data[15:8] = vpd_enable ? hsv_pkg::hs_next_pd : hsv_pkg::list_end;
        data[7:0] = hsv_pkg::hs_ident;
      end
      hsv_pkg::product_data_ofs: begin
        data[hsv_pkg::flag_pos] = flag;
        data[hsv_pkg::addr_lsb +: 8] = pd_addr;
        data[15:8] = hsv_pkg::list_end;
        data[7:0] = hsv_pkg::pd_ident;
      end
      hsv_pkg::product_word_ofs: begin
        data = pd_word;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end
endmodule : hsv_cfg_read

// file: test/hsv_checker.sv
// checker: port timing of the hot-swap and product-data entries
`timescale 1ns/1ps
module hsv_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic vpd_enable,
  input wire logic ee_req,
  input wire logic ee_write,
  input wire logic [7:0] ee_addr,
  input wire logic ee_done,
  input wire logic led_on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // a read strobe at one offset, answered on the next edge
  sequence rd_at(logic [7:0] a);
    cfg_rd && cfg_addr == a;
  endsequence
  // a flag write while idle starts a transfer
  sequence go(logic w);
    cfg_wr && cfg_addr == hsv_pkg::product_data_ofs && cfg_be[3]
      && cfg_wdata[hsv_pkg::flag_pos] == w && !ee_req;
  endsequence
  hs_id_a: assert property (rd_at(8'he4) |=> cfg_rdata[7:0] == hsv_pkg::hs_ident)
    else $error("hot-swap id wrong");
  hs_next_a: assert property (rd_at(8'he4) |=> cfg_rdata[15:8] ==
    ($past(vpd_enable) ? hsv_pkg::hs_next_pd : hsv_pkg::list_end)) else $error("pointer wrong");
  pd_fixed_a: assert property (rd_at(8'he8) |=> cfg_rdata[15:0] == 16'h0003)
    else $error("product-data id or pointer wrong");
  ee_write_a: assert property (go(1'b1) |=> ee_req && ee_write)
    else $error("write not started");
  ee_read_a: assert property (go(1'b0) |=> ee_req && !ee_write)
    else $error("read not started");
  ee_end_a: assert property (ee_req && ee_done |=> !ee_req)
    else $error("request not ended");
  ee_hold_a: assert property (ee_req && !ee_done |=> ee_req && $stable(ee_addr))
    else $error("request dropped or address moved");
  led_wr_a: assert property (cfg_wr && cfg_addr == 8'he4 && cfg_be[2]
    |=> led_on == $past(cfg_wdata[19])) else $error("led does not follow");
endmodule : hsv_checker

bind hsv_capability hsv_checker i_chk (.*);

// file: test/hsv_ee_model.sv
// serial eeprom stand-in answering product-data requests after a set delay
`timescale 1ns/1ps
module hsv_ee_model (
  input wire logic mclk,
  input wire logic ee_req,
  input wire logic ee_write,
  input wire logic [7:0] ee_addr,
  input wire logic [31:0] ee_wdata,
  input wire logic [31:0] lat,
  output logic ee_done,
  output logic [31:0] ee_rdata
);
  logic [7:0] mem [256];
  int cnt = 0;
  // preset contents; done and data are driven by the clocked process alone
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // data toggles outside done so a stale word never looks valid
  always @(posedge mclk) begin
    ee_done <= 1'b0;
    ee_rdata <= ~ee_rdata;
    cnt <= ee_req ? cnt + 1 : 0;
    if (ee_req && !ee_done && cnt == lat) begin
      ee_done <= 1'b1;
      for (int j = 0; j < 4; j++) begin
        if (ee_write) mem[ee_addr + j] <= ee_wdata[8*j +: 8];
        ee_rdata[8*j +: 8] <= mem[ee_addr + j];
      end
    end
  end
endmodule : hsv_ee_model

// file: test/tb.sv
// testbench: configuration-access tests of the hot-swap and product-data entries
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata, ee_wdata, ee_rdata, q;
  logic [7:0] ee_addr;
  logic cfg_ack, ee_req, ee_write, ee_done, led_on, enum_n;
  logic eeprom_load_done = 1'b0;
  logic pci_disable_bit = 1'b0;
  logic vpd_enable = 1'b1;
  logic handle_switch_input = 1'b0;
  int lat = 20;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  hsv_capability i_dut (.*);
  hsv_ee_model i_ee (.*);
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one strobe, dropped at the taking edge; data sampled once ack has landed
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    #1 q = cfg_rdata;
    chk("ack", cfg_ack, 32'h1);
  endtask : acc
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'h0, 32'h0);
    chk(what, q, exp);
  endtask : rdc
  task automatic set_in(input logic ld, input logic dis, input logic ve, input logic sw);
    @(posedge mclk);
    eeprom_load_done <= ld;
    pci_disable_bit <= dis;
    vpd_enable <= ve;
    handle_switch_input <= sw;
  endtask : set_in
  task automatic wait_idle();
    for (int i = 0; i < 200 && ee_req !== 1'b0; i++) @(posedge mclk);
  endtask : wait_idle
  function automatic logic [31:0] hs(input logic i, input logic e, input logic l, input logic m);
    return {8'h00, i, e, 2'b00, l, 1'b0, m, 1'b0, 16'he806};
  endfunction : hs
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rdc("hs", 8'he4, hs(0, 0, 0, 0));
    rdc("pd", 8'he8, 32'h00000003);
    rdc("word", 8'hec, 32'h0);
    rdc("unmapped", 8'hf0, 32'h0);
    set_in(0, 0, 0, 0);
    rdc("hs_end", 8'he4, 32'h00000006);
    acc(1'b1, 8'he8, 4'h3, 32'hffffffff);
    rdc("pd_ro", 8'he8, 32'h00000003);
    $display("test list done");
    set_in(1, 1, 1, 0);
    rdc("ins_blocked", 8'he4, hs(0, 0, 0, 0));
    chk("enum_idle", enum_n, 1'b1);
    set_in(1, 0, 1, 0);
    rdc("ins_set", 8'he4, hs(1, 0, 0, 0));
    chk("enum_on", enum_n, 1'b0);
    acc(1'b1, 8'he4, 4'h4, 32'h000a0000);
    chk("led", led_on, 1'b1);
    chk("masked", enum_n, 1'b1);
    set_in(0, 0, 1, 0);
    acc(1'b1, 8'he4, 4'h4, 32'h008a0000);
    rdc("ins_clr", 8'he4, hs(0, 0, 1, 1));
    set_in(0, 0, 1, 1);
    repeat (4) @(posedge mclk);
    rdc("ext_set", 8'he4, hs(0, 1, 1, 1));
    set_in(0, 0, 1, 0);
    repeat (4) @(posedge mclk);
    acc(1'b1, 8'he4, 4'h4, 32'h00400000);
    rdc("ext_clr", 8'he4, hs(0, 0, 0, 0));
    chk("led_off", led_on, 1'b0);
    $display("test hot swap done");
    // slow write, then prompt reads back and from preset contents
    acc(1'b1, 8'hec, 4'hf, 32'h44332211);
    acc(1'b1, 8'he8, 4'hc, 32'h80100000);
    rdc("busy", 8'he8, 32'h80100003);
    // flag write while busy is refused; its address byte still lands
    acc(1'b1, 8'he8, 4'hc, 32'h00300000);
    rdc("busy_refuse", 8'he8, 32'h80300003);
    wait_idle();
    rdc("wr_done", 8'he8, 32'h00300003);
    lat = 0;
    acc(1'b1, 8'hec, 4'hf, 32'h0);
    acc(1'b1, 8'he8, 4'hc, 32'h00100000);
    wait_idle();
    rdc("rd_flag", 8'he8, 32'h80100003);
    rdc("rd_back", 8'hec, 32'h44332211);
    acc(1'b1, 8'he8, 4'hc, 32'h00200000);
    wait_idle();
    rdc("rd_init", 8'hec, 32'h79787b7a);
    $display("test product data done");
    report_and_stop();
  end
endmodule : tb
